/* File: hdl/vbi_channel.sv */
// One request channel: edge-latched pending flag cleared by service.
`timescale 1ns/1ns
module vbi_channel (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic source,
    input wire logic enable,
    input wire logic served,
    output logic pending
);
    import vbi_pkg::*;
    logic sourceDly_r; // Previous source sample for edge detection
    logic rise;        // Source went active this cycle

    assign rise = source & ~sourceDly_r;

    // Edge history
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sourceDly_r <= 1'b0;
        end else begin
            sourceDly_r <= source;
        end
    end

    // A new edge in the service cycle wins, so no request is lost
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pending <= 1'b0;
        end else begin
            pending <= enable & ((pending & ~served) | rise); // RULE_16 RULE_15 RULE_11
        end
    end
endmodule

/* File: hdl/vbi_device.sv */
// Board interrupter: register slave, request drivers and chain responder.
`timescale 1ns/1ns
module vbi_device #(
    parameter int NUM_CH = 2
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    vbi_if.device bus,
    input wire logic gfxReq,
    input wire logic vsyncIn,
    output logic localIrq
);
    import vbi_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_ANSWER, ST_PASS} vbi_state_e;

    vbi_state_e state_r;              // Bus cycle state
    logic [7:0] ctrl_r [NUM_CH];      // Control per active channel
    logic [7:0] vec_r [NUM_CH];       // Vector per active channel
    logic [NUM_CH-1:0] status_r;      // Sticky service events
    logic [NUM_CH-1:0] mask_r;        // Local interrupt mask
    logic [NUM_CH-1:0] pending;       // Channel requests waiting
    logic [NUM_CH-1:0] source;        // Raw channel sources
    logic [NUM_CH-1:0] served;        // One-cycle service pulse per channel
    logic [NUM_CH-1:0] hitMask;       // Channels matching the acknowledged level
    logic [NUM_LEVELS:1] irqWant;     // Levels with a live request
    logic regCycle;                   // Register access starts this cycle
    logic ackCycle;                   // Chain reached us in an acknowledge cycle
    logic hitAny;                     // Some channel answers this acknowledge
    logic statusRead;                 // Status is read this cycle
    logic [7:0] hitVector;            // Vector of the answering channel
    logic [7:0] readByte;             // Register read mux

    // Channel two is graphics, channel three vertical sync
    assign source = {vsyncIn, gfxReq}; // RULE_09 RULE_14

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
            vbi_channel u_ch (
                .sys_clk(sys_clk),
                .reset_n(reset_n),
                .source(source[gi]),
                .enable(ctrl_r[gi][CTRL_ENABLE_BIT]),
                .served(served[gi]),
                .pending(pending[gi])
            );
        end
    endgenerate

    // Cycle qualifiers; an acknowledge only counts once the chain input arrives
    assign regCycle = (state_r == ST_IDLE) && !bus.addrStrobeN && bus.iackN && !bus.selectN;
    assign ackCycle = (state_r == ST_IDLE) && !bus.addrStrobeN && !bus.iackN
        && !bus.iackInN; // RULE_03 RULE_04
    assign statusRead = regCycle && bus.writeN && (bus.addr == OFF_IRQ_STATUS[ADDR_W-1:1]);

    // Level match; vectors only come from channels set for internal generation
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            hitMask[i] = pending[i] && ctrl_r[i][CTRL_INT_VEC_BIT]
                && (ctrl_r[i][CTRL_LEVEL_LSB +: CTRL_LEVEL_W] == bus.addr[3:1]); // RULE_12
        end
    end

    // Lowest channel wins when both share the acknowledged level
    always_comb begin
        hitAny = 1'b0;
        hitVector = 8'h00;
        served = '0;
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (hitMask[i]) begin
                hitAny = 1'b1;
                hitVector = vec_r[i];
                served = '0;
                served[i] = ackCycle;
            end
        end
    end

    // Request levels; level code zero keeps a channel off the backplane
    always_comb begin
        irqWant = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            for (int l = 1; l <= NUM_LEVELS; l++) begin
                if (pending[i] && ctrl_r[i][CTRL_LEVEL_LSB +: CTRL_LEVEL_W] == 3'(l)) begin
                    irqWant[l] = 1'b1; // RULE_01 RULE_08
                end
            end
        end
    end

    // Open-drain request drivers, several levels may be pulled at once
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            bus.irqOeN <= '1;
        end else begin
            bus.irqOeN <= ~(irqWant & ~served_levels(served)); // RULE_02 RULE_15
        end
    end

    // Levels of channels serviced this cycle, dropped at once
    function automatic logic [NUM_LEVELS:1] served_levels(input logic [NUM_CH-1:0] s);
        logic [NUM_LEVELS:1] lv;
        lv = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            if (s[i] && !(pending[i] & ~hitMask[i])) begin
                for (int l = 1; l <= NUM_LEVELS; l++) begin
                    if (ctrl_r[i][CTRL_LEVEL_LSB +: CTRL_LEVEL_W] == 3'(l)) begin
                        lv[l] = 1'b1;
                    end
                end
            end
        end
        // Keep a level held if another channel still wants it
        for (int i = 0; i < NUM_CH; i++) begin
            if (pending[i] && !s[i]) begin
                for (int l = 1; l <= NUM_LEVELS; l++) begin
                    if (ctrl_r[i][CTRL_LEVEL_LSB +: CTRL_LEVEL_W] == 3'(l)) begin
                        lv[l] = 1'b0;
                    end
                end
            end
        end
        return lv;
    endfunction

    // Register read mux; spare channels read as reserved
    always_comb begin
        case (bus.addr)
            OFF_IRQ_CTRL_GFX[ADDR_W-1:1]: readByte = ctrl_r[0];
            OFF_IRQ_CTRL_VSYNC[ADDR_W-1:1]: readByte = ctrl_r[1];
            OFF_IRQ_VECTOR_GFX[ADDR_W-1:1]: readByte = vec_r[0];
            OFF_IRQ_VECTOR_VSYNC[ADDR_W-1:1]: readByte = vec_r[1];
            OFF_IRQ_STATUS[ADDR_W-1:1]: readByte = 8'(status_r);
            OFF_IRQ_MASK[ADDR_W-1:1]: readByte = 8'(mask_r);
            default: readByte = RSVD_READ; // RULE_14
        endcase
    end

    // Control and vector writes; reset leaves every channel disabled
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < NUM_CH; i++) begin
                ctrl_r[i] <= CTRL_RESET; // RULE_11
                vec_r[i] <= VECTOR_RESET;
            end
        end else if (regCycle && !bus.writeN) begin
            case (bus.addr)
                OFF_IRQ_CTRL_GFX[ADDR_W-1:1]: ctrl_r[0] <= bus.data[7:0]; // RULE_10
                OFF_IRQ_CTRL_VSYNC[ADDR_W-1:1]: ctrl_r[1] <= bus.data[7:0]; // RULE_10
                OFF_IRQ_VECTOR_GFX[ADDR_W-1:1]: vec_r[0] <= bus.data[7:0]; // RULE_10
                OFF_IRQ_VECTOR_VSYNC[ADDR_W-1:1]: vec_r[1] <= bus.data[7:0]; // RULE_10
                default: ;
            endcase
        end
    end

    // Mask register
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            mask_r <= MASK_RESET;
        end else if (regCycle && !bus.writeN && bus.addr == OFF_IRQ_MASK[ADDR_W-1:1]) begin
            mask_r <= bus.data[NUM_CH-1:0];
        end
    end

    // Sticky service events; a service in the read cycle survives the clear
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            status_r <= '0;
        end else begin
            status_r <= (statusRead ? '0 : status_r) | served;
        end
    end

    // Local level interrupt
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            localIrq <= 1'b0;
        end else begin
            localIrq <= |(((statusRead ? '0 : status_r) | served) & mask_r);
        end
    end

    // Bus cycle sequencer: answer, pass on, or hold until the strobe lifts
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_IDLE;
            bus.dtackOeN <= 1'b1;
            bus.devDataOeN <= 1'b1;
            bus.devData <= '1;
            bus.iackOutN <= 1'b1;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (ackCycle && hitAny) begin
                        bus.devData <= {UPPER_BYTE, hitVector}; // RULE_05
                        bus.devDataOeN <= 1'b0;
                        bus.dtackOeN <= 1'b0; // RULE_05
                        state_r <= ST_ANSWER;
                    end else if (ackCycle) begin
                        bus.iackOutN <= 1'b0; // RULE_06 RULE_04
                        state_r <= ST_PASS;
                    end else if (regCycle) begin
                        bus.devData <= {UPPER_BYTE, readByte}; // RULE_13
                        bus.devDataOeN <= !bus.writeN;
                        bus.dtackOeN <= 1'b0;
                        state_r <= ST_ANSWER;
                    end
                end
                ST_ANSWER: begin
                    // Vector and acknowledge stand until the strobe is released
                    if (bus.addrStrobeN) begin
                        bus.dtackOeN <= 1'b1; // RULE_07
                        bus.devDataOeN <= 1'b1;
                        state_r <= ST_IDLE;
                    end
                end
                ST_PASS: begin
                    if (bus.addrStrobeN) begin
                        bus.iackOutN <= 1'b1;
                        state_r <= ST_IDLE;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

/* File: hdl/vbi_host.sv */
// Interrupt handler end: runs register and acknowledge cycles on command.
`timescale 1ns/1ns
module vbi_host (
    input wire logic sys_clk,
    input wire logic reset_n,
    vbi_if.host bus,
    input wire logic [2:0] swAddr,
    input wire logic [15:0] swWdata,
    input wire logic swWr,
    input wire logic swRd,
    output logic [15:0] swRdata
);
    import vbi_pkg::*;

    typedef enum logic [1:0] {HS_IDLE, HS_SETUP, HS_WAIT, HS_RELEASE} vbi_hstate_e;

    vbi_hstate_e state_r;         // Cycle state
    logic [ADDR_W-1:0] target_r;  // Byte offset, or level code in bits 3:1
    logic [7:0] wdata_r;          // Byte to write
    logic [1:0] cmd_r;            // Command in progress
    logic done_r;                 // Last cycle finished
    logic passed_r;               // Last acknowledge fell off the chain
    logic [15:0] result_r;        // Data of the last answered cycle: read data, vector or written word
    logic isAck;                  // Command is an acknowledge cycle
    logic start;                  // Command accepted this cycle

    assign isAck = (cmd_r == HCMD_IACK);
    assign start = swWr && swAddr == HREG_CMD && state_r == HS_IDLE && swWdata[1:0] != 2'h0;

    // Software settings; a command write while busy is ignored
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            target_r <= '0;
            wdata_r <= '0;
            cmd_r <= '0;
        end else if (swWr) begin
            case (swAddr)
                HREG_TARGET: target_r <= swWdata[ADDR_W-1:0];
                HREG_WDATA: wdata_r <= swWdata[7:0];
                HREG_CMD: if (start) cmd_r <= swWdata[1:0];
                default: ;
            endcase
        end
    end

    // Software read port, data one cycle after the strobe
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            swRdata <= '0;
        end else if (swRd) begin
            case (swAddr)
                HREG_TARGET: swRdata <= 16'(target_r);
                HREG_WDATA: swRdata <= 16'(wdata_r);
                HREG_STATUS: swRdata <= 16'({passed_r, done_r, state_r != HS_IDLE});
                HREG_RDATA: swRdata <= result_r;
                HREG_IRQ: swRdata <= 16'({~bus.irqN, 1'b0}); // RULE_01
                default: swRdata <= '0;
            endcase
        end
    end

    // Backplane cycle: address and strobe on the same edge, release when answered or passed on
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= HS_IDLE;
            bus.addrStrobeN <= 1'b1;
            bus.iackN <= 1'b1;
            bus.iackInN <= 1'b1;
            bus.selectN <= 1'b1;
            bus.writeN <= 1'b1;
            bus.addr <= '0;
            bus.hostData <= '1;
            bus.hostDataOeN <= 1'b1;
            done_r <= 1'b0;
            passed_r <= 1'b0;
            result_r <= '0;
        end else begin
            case (state_r)
                HS_IDLE: begin
                    if (start) begin
                        done_r <= 1'b0;
                        passed_r <= 1'b0;
                        state_r <= HS_SETUP;
                    end
                end
                HS_SETUP: begin
                    bus.addr <= target_r[ADDR_W-1:1]; // RULE_03
                    bus.iackN <= !isAck; // RULE_03
                    bus.selectN <= isAck;
                    bus.writeN <= (cmd_r != HCMD_WRITE);
                    bus.hostData <= {UPPER_BYTE, wdata_r};
                    bus.hostDataOeN <= (cmd_r != HCMD_WRITE);
                    bus.addrStrobeN <= 1'b0; // RULE_03
                    bus.iackInN <= !isAck;
                    state_r <= HS_WAIT;
                end
                HS_WAIT: begin
                    // Lift the strobe once answered or passed down the chain; the answer is latched here
                    if (!bus.dtackN) begin
                        result_r <= bus.data;
                        bus.addrStrobeN <= 1'b1; // RULE_07
                        bus.iackInN <= 1'b1;
                        state_r <= HS_RELEASE;
                    end else if (!bus.iackOutN) begin
                        passed_r <= 1'b1;
                        bus.addrStrobeN <= 1'b1;
                        bus.iackInN <= 1'b1;
                        state_r <= HS_RELEASE;
                    end
                end
                HS_RELEASE: begin
                    if (bus.dtackN && bus.iackOutN) begin
                        bus.iackN <= 1'b1;
                        bus.selectN <= 1'b1;
                        bus.writeN <= 1'b1;
                        bus.hostDataOeN <= 1'b1;
                        done_r <= 1'b1;
                        state_r <= HS_IDLE;
                    end
                end
                default: begin
                    state_r <= HS_IDLE;
                end
            endcase
        end
    end
endmodule

/* File: include/vbi_if.sv */
// Backplane wires between the interrupter and the interrupt handler.
`timescale 1ns/1ns
interface vbi_if;
    import vbi_pkg::*;
    logic addrStrobeN;          // Address strobe from handler
    logic iackN;                // Acknowledge cycle marker
    logic iackInN;              // Chain input of the interrupter slot
    logic iackOutN;             // Chain output toward the next slot
    logic selectN;              // Board decode: interrupter_select
    logic writeN;               // Low for a write cycle
    logic [ADDR_W-1:1] addr;    // Word address, level code in [3:1] on acknowledge
    logic [15:0] hostData;      // Data driven by the handler
    logic hostDataOeN;          // Handler drives data while low
    logic [15:0] devData;       // Data driven by the interrupter
    logic devDataOeN;           // Interrupter drives data while low
    logic dtackOeN;             // Interrupter pulls acknowledge low while low
    logic [NUM_LEVELS:1] irqOeN; // Interrupter pulls request line low while low
    logic dtackN;               // Resolved open-drain acknowledge
    logic [NUM_LEVELS:1] irqN;  // Resolved open-drain request lines
    logic [15:0] data;          // Resolved data bus
    // Open-drain lines idle high through pull-ups
    assign dtackN = dtackOeN;
    assign irqN = irqOeN;
    assign data = !devDataOeN ? devData : (!hostDataOeN ? hostData : 16'hffff);
    modport device (
        input addrStrobeN, iackN, iackInN, selectN, writeN, addr, data,
        output iackOutN, devData, devDataOeN, dtackOeN, irqOeN
    );
    modport host (
        input iackOutN, dtackN, irqN, data,
        output addrStrobeN, iackN, iackInN, selectN, writeN, addr, hostData, hostDataOeN
    );
endinterface

/* File: include/vbi_pkg.sv */
// Shared constants and types for the backplane interrupter and its handler.
// Functional notes
// (RULE_01) Seven request lines; level seven wins.
// (RULE_02) Wired-or request drivers; several levels at once.
// (RULE_03) Handler acknowledges: ack line, level code, strobe.
// (RULE_04) Chain input in, chain output to next.
// (RULE_05) Pending on level: answer vector and acknowledge.
// (RULE_06) Nothing pending: pass acknowledge down the chain.
// (RULE_07) Answer holds until handler releases strobe.
// (RULE_08) Any of seven lines, several together.
// (RULE_09) Graphics and vertical sync use separate channels.
// (RULE_10) Level and vector set per channel.
// (RULE_11) Reset blocks all requests until initialised.
// (RULE_12) Software selects internal vector generation.
// (RULE_13) Word access, low byte data, upper ones.
// (RULE_14) Channels one, four spare; two gfx, three sync.
// (RULE_15) Serviced channel drops its request line.
// (RULE_16) Sync edge latches request when channel enabled.
package vbi_pkg;
    localparam int NUM_LEVELS = 7;
    localparam int ADDR_W = 5;
    // Register byte offsets on the board slave port
    localparam logic [4:0] OFF_IRQ_CTRL_SPARE_A = 5'h00;
    localparam logic [4:0] OFF_IRQ_CTRL_GFX = 5'h02;
    localparam logic [4:0] OFF_IRQ_CTRL_VSYNC = 5'h04;
    localparam logic [4:0] OFF_IRQ_CTRL_SPARE_B = 5'h06;
    localparam logic [4:0] OFF_IRQ_VECTOR_SPARE_A = 5'h08;
    localparam logic [4:0] OFF_IRQ_VECTOR_GFX = 5'h0a;
    localparam logic [4:0] OFF_IRQ_VECTOR_VSYNC = 5'h0c;
    localparam logic [4:0] OFF_IRQ_VECTOR_SPARE_B = 5'h0e;
    localparam logic [4:0] OFF_IRQ_STATUS = 5'h10;
    localparam logic [4:0] OFF_IRQ_MASK = 5'h12;
    // Control register fields
    localparam int CTRL_LEVEL_LSB = 0;
    localparam int CTRL_LEVEL_W = 3;
    localparam int CTRL_ENABLE_BIT = 4;
    localparam int CTRL_INT_VEC_BIT = 5;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] VECTOR_RESET = 8'h0f;
    localparam logic [7:0] UPPER_BYTE = 8'hff;
    localparam logic [7:0] RSVD_READ = 8'h00;
    // Status and mask bit positions
    localparam int STAT_GFX_BIT = 0;
    localparam int STAT_VSYNC_BIT = 1;
    localparam logic [1:0] MASK_RESET = 2'h0;
    // Handler command port register indices
    localparam logic [2:0] HREG_TARGET = 3'h0;
    localparam logic [2:0] HREG_WDATA = 3'h1;
    localparam logic [2:0] HREG_CMD = 3'h2;
    localparam logic [2:0] HREG_STATUS = 3'h3;
    localparam logic [2:0] HREG_RDATA = 3'h4;
    localparam logic [2:0] HREG_IRQ = 3'h5;
    // Handler commands written to HREG_CMD
    localparam logic [1:0] HCMD_WRITE = 2'h1;
    localparam logic [1:0] HCMD_READ = 2'h2;
    localparam logic [1:0] HCMD_IACK = 2'h3;
    // Handler status bits
    localparam int HSTAT_BUSY_BIT = 0;
    localparam int HSTAT_DONE_BIT = 1;
    localparam int HSTAT_PASSED_BIT = 2;
endpackage

/* File: verif/vbi_checker.sv */
// Backplane protocol checker watching the interrupter and handler wires.
`timescale 1ns/1ns
module vbi_checker (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic addrStrobeN,
    input wire logic iackN,
    input wire logic iackInN,
    input wire logic iackOutN,
    input wire logic selectN,
    input wire logic writeN,
    input wire logic [vbi_pkg::ADDR_W-1:1] addr,
    input wire logic dtackN,
    input wire logic devDataOeN,
    input wire logic [vbi_pkg::NUM_LEVELS:1] irqN,
    input wire logic [15:0] data
);
    import vbi_pkg::*;
    logic [7:0] reqLine; // Active requests; bit 0 means no level
    logic lvlReq; // Request present on the level being acknowledged
    assign reqLine = ~{irqN, 1'b1};
    assign lvlReq = reqLine[addr[3:1]];
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // A taken strobe gets an answer or a pass within two edges
    ans_soon_a: assert property ($fell(addrStrobeN) && (!selectN || !iackN)
        |-> ##[1:2] (!dtackN || !iackOutN)) else $error("strobe not answered");
    // Answer stays while the strobe is still low
    ans_hold_a: assert property (!dtackN && !addrStrobeN |=> !dtackN)
        else $error("dtack dropped early");
    // Two edges of released strobe and the interrupter lets go of acknowledge, chain output and data
    bus_idle_a: assert property (addrStrobeN && $past(addrStrobeN)
        |-> dtackN && iackOutN && devDataOeN) else $error("bus not released");
    upper_ones_a: assert property (!dtackN && (!iackN || writeN)
        |-> data[15:8] == UPPER_BYTE) else $error("upper byte not ones");
    // Passing and answering never overlap, and passing is only in ack cycles
    chain_excl_a: assert property (!iackOutN |-> dtackN && !iackN)
        else $error("pass with answer");
    chain_cause_a: assert property ($fell(iackOutN)
        |-> !$past(iackInN) && !$past(addrStrobeN)) else $error("pass without chain in");
    // A vector is only given for a level that this board requests
    lvl_match_a: assert property ($fell(dtackN) && !iackN |-> $past(lvlReq))
        else $error("vector on idle level");
    irq_reset_a: assert property ($rose(reset_n) |-> &irqN)
        else $error("request out of reset");
    cover property ($fell(dtackN) && !iackN);
    cover property ($fell(iackOutN));
    cover property (reqLine[2] && reqLine[6]);
endmodule

/* File: verif/vme_board_interrupter_test.sv */
// Testbench for the interrupter and handler joined on one backplane.
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("BAD %s exp %h got %h", nm, exp, got); end end
module vme_board_interrupter_test;
    import vbi_pkg::*;
    logic sys_clk, reset_n, gfxReq, vsyncIn, swWr, swRd, localIrq;
    logic [2:0] swAddr;
    logic [15:0] swWdata, swRdata, res, hst; // Result and handler status
    int n_mismatch = 0;
    int compares = 0;
    int cycles = 0;
    vbi_if bus();
    vbi_device #(.NUM_CH(2)) u_vbi_device (.sys_clk(sys_clk), .reset_n(reset_n), .bus(bus),
        .gfxReq(gfxReq), .vsyncIn(vsyncIn), .localIrq(localIrq));
    vbi_host u_vbi_host (.sys_clk(sys_clk), .reset_n(reset_n), .bus(bus), .swAddr(swAddr),
        .swWdata(swWdata), .swWr(swWr), .swRd(swRd), .swRdata(swRdata));
    vbi_checker u_vbi_checker (.sys_clk(sys_clk), .reset_n(reset_n),
        .addrStrobeN(bus.addrStrobeN), .iackN(bus.iackN), .iackInN(bus.iackInN),
        .iackOutN(bus.iackOutN), .selectN(bus.selectN), .writeN(bus.writeN),
        .addr(bus.addr), .dtackN(bus.dtackN), .devDataOeN(bus.devDataOeN),
        .irqN(bus.irqN), .data(bus.data));
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // Hang guard: the whole run needs a few thousand cycles at most
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            close_out();
        end
    end
    task automatic sw_wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        swAddr <= a;
        swWdata <= d;
        swWr <= 1'b1;
        @(posedge sys_clk);
        swWr <= 1'b0;
    endtask
    // Read data lands at the edge after the strobe
    task automatic sw_rd(input logic [2:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        swAddr <= a;
        swRd <= 1'b1;
        @(posedge sys_clk);
        swRd <= 1'b0;
        #1 d = swRdata;
    endtask
    // One handler command, polled until idle, then its result fetched
    task automatic hcmd(input logic [4:0] tgt, input logic [7:0] wd, input logic [1:0] op);
        sw_wr(HREG_TARGET, {11'h000, tgt});
        sw_wr(HREG_WDATA, {8'h00, wd});
        sw_wr(HREG_CMD, {14'h0000, op});
        hst = 16'h0001;
        for (int i = 0; i < 40 && hst[HSTAT_BUSY_BIT] !== 1'b0; i++) sw_rd(HREG_STATUS, hst);
        `CHK("done", 1'b1, hst[HSTAT_DONE_BIT])
        sw_rd(HREG_RDATA, res);
    endtask
    // Source pulse long enough for an edge to be latched
    task automatic pulse(input logic g, input logic v);
        @(posedge sys_clk);
        gfxReq <= g;
        vsyncIn <= v;
        repeat (2) @(posedge sys_clk);
        gfxReq <= 1'b0;
        vsyncIn <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
    endtask
    task automatic t_reset();
        `CHK("irq idle", 7'h7f, bus.irqN)
        hcmd(OFF_IRQ_CTRL_GFX, 8'h00, HCMD_READ);
        `CHK("ctrl rst", {UPPER_BYTE, CTRL_RESET}, res)
        hcmd(OFF_IRQ_VECTOR_VSYNC, 8'h00, HCMD_READ);
        `CHK("vec rst", {UPPER_BYTE, VECTOR_RESET}, res)
        pulse(1'b1, 1'b1);
        `CHK("blocked", 7'h7f, bus.irqN)
        hcmd(OFF_IRQ_CTRL_SPARE_B, 8'h33, HCMD_WRITE);
        hcmd(OFF_IRQ_CTRL_SPARE_B, 8'h00, HCMD_READ);
        `CHK("spare", {UPPER_BYTE, RSVD_READ}, res)
        $display("reset test done");
    endtask
    // Every level in turn: request, acknowledge, vector, release
    task automatic t_levels();
        for (int l = 1; l <= 7; l++) begin
            hcmd(OFF_IRQ_CTRL_GFX, 8'h30 | 8'(l), HCMD_WRITE);
            hcmd(OFF_IRQ_VECTOR_GFX, 8'h80 + 8'(l), HCMD_WRITE);
            hcmd(OFF_IRQ_CTRL_GFX, 8'h00, HCMD_READ);
            `CHK("ctrl rd", {UPPER_BYTE, 8'h30 | 8'(l)}, res)
            pulse(1'b1, 1'b0);
            `CHK("line", 7'(~(7'h01 << (l - 1))), bus.irqN)
            hcmd(5'(l << 1), 8'h00, HCMD_IACK);
            `CHK("vector", {UPPER_BYTE, 8'h80 + 8'(l)}, res)
            `CHK("released", 7'h7f, bus.irqN)
            `CHK("masked", 1'b0, localIrq)
        end
        $display("levels test done");
    endtask
    // Both channels at once, chain pass, status and mask, disabled channel
    task automatic t_both();
        hcmd(OFF_IRQ_CTRL_GFX, 8'h32, HCMD_WRITE);
        hcmd(OFF_IRQ_CTRL_VSYNC, 8'h36, HCMD_WRITE);
        hcmd(OFF_IRQ_VECTOR_VSYNC, 8'h5a, HCMD_WRITE);
        hcmd(OFF_IRQ_MASK, 8'h03, HCMD_WRITE);
        hcmd(OFF_IRQ_STATUS, 8'h00, HCMD_READ);
        pulse(1'b1, 1'b1);
        `CHK("two lines", 7'h5d, bus.irqN)
        sw_rd(HREG_IRQ, res);
        `CHK("irq reg", 16'h0044, res)
        hcmd(5'h0c, 8'h00, HCMD_IACK);
        `CHK("sync vec", 16'hff5a, res)
        `CHK("one left", 7'h7d, bus.irqN)
        `CHK("irq on", 1'b1, localIrq)
        hcmd(OFF_IRQ_STATUS, 8'h00, HCMD_READ);
        `CHK("status", {UPPER_BYTE, 8'h02}, res)
        `CHK("irq clr", 1'b0, localIrq)
        hcmd(5'h06, 8'h00, HCMD_IACK);
        `CHK("passed", 1'b1, hst[HSTAT_PASSED_BIT])
        hcmd(OFF_IRQ_MASK, 8'h00, HCMD_WRITE);
        hcmd(5'h04, 8'h00, HCMD_IACK);
        `CHK("gfx vec", 16'hff87, res)
        `CHK("mask off", 1'b0, localIrq)
        hcmd(OFF_IRQ_CTRL_GFX, 8'h22, HCMD_WRITE);
        pulse(1'b1, 1'b0);
        `CHK("disabled", 7'h7f, bus.irqN)
        // Enabled but without internal vector: line pulled, acknowledge passed on
        hcmd(OFF_IRQ_CTRL_GFX, 8'h12, HCMD_WRITE);
        pulse(1'b1, 1'b0);
        hcmd(5'h04, 8'h00, HCMD_IACK);
        `CHK("no int vec", 1'b1, hst[HSTAT_PASSED_BIT])
        `CHK("still up", 7'h7d, bus.irqN)
        $display("both test done");
    endtask
    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        reset_n = 1'b0;
        gfxReq = 1'b0;
        vsyncIn = 1'b0;
        swWr = 1'b0;
        swRd = 1'b0;
        swAddr = 3'h0;
        swWdata = 16'h0000;
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        t_reset();
        t_levels();
        t_both();
        close_out();
    end
endmodule
